// >>> hw/mb_acyc_regs.svh
// Constants for the non-cyclic parameter access and control word block.
// Assumes inclusion by bare name from the design file and the bench.
`ifndef MB_ACYC_REGS_SVH
`define MB_ACYC_REGS_SVH
// Base of the non-cyclic holding register area
`define ACYC_BASE_ADDR 16'h0210
// Function codes served
`define FC_READ_HOLDING 8'h03
`define FC_WRITE_SINGLE 8'h06
`define FC_WRITE_MULTI 8'h10
`define FC_READ_WRITE_MULTI 8'h17
// Exception codes of the answer
`define EXC_ILLEGAL_FUNC 8'h01
`define EXC_ILLEGAL_ADDR 8'h02
`define EXC_ILLEGAL_DATA 8'h03
// Parameter numbers held locally, and the first number outside menu zero
`define PNUM_CTRL_WORD 16'h0282
`define PNUM_WORDS_PER_PARAM 16'h05e5
`define PNUM_MENU_ONE 16'h0064
// Reset values
`define WORDS_PER_PARAM_RESET 1'b1
`define CTRL_WORD_RESET 16'h0000
// Control word field positions
`define CW_ENABLE 0
`define CW_RUN_FWD 1
`define CW_JOG 2
`define CW_RUN_REV 3
`define CW_DIR_REV 4
`define CW_RUN 5
`define CW_REF_SEL 8
`define CW_TRIP_RESET 13
// Writable bits; all others are reserved and kept at zero
`define CW_DEFINED_MASK 16'h213f
`endif

// >>> hw/mb_acyc_pkg.sv
// Types shared by the non-cyclic access block and its bench.
// Assumes the constants header sits beside it.
package mb_acyc_pkg;
   // Request handling states, Gray along the path
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DECODE = 2'b01,
      ST_CHECK = 2'b11,
      ST_ANSWER = 2'b10
   } st_t;
   // One decoded request from the frame layer
   typedef struct packed {
      logic [7:0] fc;
      logic [15:0] addr;
      logic [15:0] qty;
      logic [15:0] word0;
      logic [15:0] word1;
   } req_t;
   // Answer back to the frame layer
   typedef struct packed {
      logic exc;
      logic [7:0] code;
      logic [31:0] data;
   } rsp_t;
   // Decoded drive commands
   typedef struct packed {
      logic enable;
      logic run_fwd;
      logic jog;
      logic run_rev;
      logic dir_rev;
      logic run;
      logic ref_digital;
   } drv_cmd_t;
endpackage

// >>> hw/modbus_acyclic_param_ctrl_word.sv
// Non-cyclic parameter access over holding registers, and control word decode.
// Assumes a frame layer on CLK_IN hands over decoded requests, and a drive
// parameter table answers within one cycle of PAR_NUM_OUT.
// Notes on behaviour
// [R1] Words-per-parameter selection, reset to two
// [R2] One-word layout refuses 32-bit parameters
// [R3] Serve function codes 3, 6, 16, 23
// [R4] Non-cyclic area starts at 528
// [R5] Two-word address is 528 + 2*(param-1)
// [R6] One-word address is 528 + param - 1
// [R7] Master adds one if it subtracts one
// [R8] Menu zero is not mapped
// [R9] Single-register write to 32-bit refused
// [R10] 32-bit access shorter than 32 bits refused
// [R11] First access clears output mapping without cyclic
// [R12] Control word bit positions decoded
// [R13] Master writes reserved bits as zero
// [R14] Control word acts only with fieldbus source
// [R15] Start needs both safe torque off inputs
// [R16] Reference bit selects digital or analog reference
// [R17] Digital reference one unless preset selector
// [R18] Control word carried 32-bit when uncompressed
// [R19] Trip cleared on rising reset bit only
// [R20] Invalid requests get an exception answer
`timescale 1ns/1ps
`include "mb_acyc_regs.svh"
module modbus_acyclic_param_ctrl_word
   import mb_acyc_pkg::*;
#(
   parameter int SYNC_STAGES = 2 // Synchroniser depth for pin inputs
)
(
   input wire logic CLK_IN,
   input wire logic RST_IN,
   input wire logic REQ_VALID_IN,
   input wire req_t REQ_IN,
   output logic REQ_READY_OUT,
   output logic RSP_VALID_OUT,
   output rsp_t RSP_OUT,
   output logic [15:0] PAR_NUM_OUT,
   input wire logic PARAM_WIDE_IN,
   input wire logic [31:0] PAR_RDATA_IN,
   output logic PAR_WR_OUT,
   output logic PAR_RD_OUT,
   output logic [31:0] PAR_WDATA_OUT,
   output logic MAP_CLEAR_OUT,
   input wire logic FIELDBUS_SRC_IN,
   input wire logic STO_A_IN,
   input wire logic STO_B_IN,
   input wire logic CYCLIC_ACTIVE_IN,
   input wire logic COMPRESS_IN,
   input wire logic [3:0] PRESET_SEL_IN,
   output drv_cmd_t DRV_CMD_OUT,
   output logic TRIP_RESET_OUT,
   output logic [31:0] CTRL_WORD_OUT,
   output logic CTRL_WIDE_OUT,
   output logic [3:0] DIG_REF_SEL_OUT
);
   // Refuse a synchroniser too short to settle metastability
   if (SYNC_STAGES < 2) begin : g_bad_sync
      $error("SYNC_STAGES must be at least 2");
   end

   // Pin inputs pass the synchroniser; only the last stage is read
   logic [SYNC_STAGES-1:0] sync [9]; // One chain per pin bit
   logic [8:0] pins; // Raw pin bits
   logic [8:0] pin_s; // Synchronised pin bits
   assign pins = {PRESET_SEL_IN, COMPRESS_IN, CYCLIC_ACTIVE_IN, STO_B_IN, STO_A_IN,
                  FIELDBUS_SRC_IN};
   for (genvar i = 0; i < 9; i++) begin : g_sync
      always_ff @(posedge CLK_IN)
      begin
         if (RST_IN)
            sync[i] <= '0;
         else
            sync[i] <= {sync[i][SYNC_STAGES-2:0], pins[i]};
      end
      assign pin_s[i] = sync[i][SYNC_STAGES-1];
   end
   logic fb_src, sto_ok; // Fieldbus source selected, both enables present
   assign fb_src = pin_s[0];
   assign sto_ok = pin_s[1] & pin_s[2];

   // Request engine state
   st_t state, next_state;
   req_t req, next_req; // Captured request
   logic [15:0] pnum, next_pnum; // Decoded parameter number
   logic [7:0] pre_code, next_pre_code; // Exception found while decoding, 0 if none
   logic wpp, next_wpp; // Words per parameter: 0 one, 1 two
   logic [15:0] ctrl, next_ctrl; // Stored control word
   logic first_done, next_first_done; // A non-cyclic access has been handled without exception
   logic ready, next_ready;
   logic rsp_valid, next_rsp_valid;
   rsp_t rsp, next_rsp;
   logic par_wr, next_par_wr;
   logic par_rd, next_par_rd;
   logic [31:0] wdata, next_wdata;
   logic map_clear, next_map_clear;
   logic [15:0] off; // Offset into the non-cyclic area
   logic is_wr, is_rd, fc_ok; // Request kind
   logic [31:0] wval; // Value assembled from the request words
   logic [7:0] code; // Final exception code
   assign off = req.addr - `ACYC_BASE_ADDR;
   assign is_rd = (req.fc == `FC_READ_HOLDING) || (req.fc == `FC_READ_WRITE_MULTI);
   assign is_wr = (req.fc == `FC_WRITE_SINGLE) || (req.fc == `FC_WRITE_MULTI) ||
                  (req.fc == `FC_READ_WRITE_MULTI);
   assign fc_ok = is_rd | is_wr; // [R3]

   // Next values of the request engine
   always_comb
   begin
      next_state = state;
      next_req = req;
      next_pnum = pnum;
      next_pre_code = pre_code;
      next_wpp = wpp;
      next_ctrl = ctrl;
      next_first_done = first_done;
      next_rsp_valid = 1'b0;
      next_rsp = rsp;
      next_par_wr = 1'b0;
      next_par_rd = 1'b0;
      next_wdata = wdata;
      next_map_clear = 1'b0;
      code = 8'h00;
      // High word travels first when two registers come; a lone register is the low word
      wval = (wpp && req.qty != 16'h0001) ? {req.word0, req.word1} : {16'h0000, req.word0};
      case (state)
         ST_IDLE:
         begin
            // Take any offered request while idle; ready itself is not checked
            if (REQ_VALID_IN)
            begin
               next_req = REQ_IN;
               next_state = ST_DECODE;
            end
         end
         ST_DECODE:
         begin
            // Map the address onto a parameter number
            if (wpp)
               next_pnum = {1'b0, off[15:1]} + 16'h0001; // [R5]
            else
               next_pnum = off + 16'h0001; // [R6]
            if (!fc_ok)
               next_pre_code = `EXC_ILLEGAL_FUNC; // [R20]
            else if (req.addr < `ACYC_BASE_ADDR)
               next_pre_code = `EXC_ILLEGAL_ADDR; // [R4]
            else if (wpp && off[0])
               next_pre_code = `EXC_ILLEGAL_ADDR; // Misaligned in two-word layout
            else if (req.qty == 16'h0000 || req.qty > {15'h0000, wpp} + 16'h0001)
               next_pre_code = `EXC_ILLEGAL_DATA; // One parameter per request
            else
               next_pre_code = 8'h00;
            next_state = ST_CHECK;
         end
         ST_CHECK:
         begin
            // The parameter table answers for PAR_NUM_OUT during this cycle
            if (pre_code != 8'h00)
               code = pre_code;
            else if (pnum < `PNUM_MENU_ONE)
               code = `EXC_ILLEGAL_ADDR; // [R8]
            else if (PARAM_WIDE_IN && !wpp)
               code = `EXC_ILLEGAL_ADDR; // [R2]
            else if (PARAM_WIDE_IN && req.fc == `FC_WRITE_SINGLE)
               code = `EXC_ILLEGAL_FUNC; // [R9]
            else if (PARAM_WIDE_IN && req.qty < 16'h0002)
               code = `EXC_ILLEGAL_DATA; // [R10]
            else if (is_wr && pnum == `PNUM_WORDS_PER_PARAM && wval > 32'h1)
               code = `EXC_ILLEGAL_DATA; // Only 0 or 1 is a legal layout
            next_rsp.exc = (code != 8'h00); // [R20]
            next_rsp.code = code;
            next_rsp.data = 32'h0;
            if (code == 8'h00)
            begin
               // First good access without cyclic exchange clears output mapping
               next_first_done = 1'b1;
               next_map_clear = !first_done && !pin_s[3]; // [R11]
               if (is_wr)
               begin
                  if (pnum == `PNUM_WORDS_PER_PARAM)
                     next_wpp = wval[0]; // [R1]
                  else if (pnum == `PNUM_CTRL_WORD)
                     next_ctrl = wval[15:0] & `CW_DEFINED_MASK; // [R13]
                  else
                     next_par_wr = 1'b1;
                  next_wdata = wval;
               end
               if (is_rd)
               begin
                  // Locally held parameters answer from here; FC23 reads back
                  if (pnum == `PNUM_WORDS_PER_PARAM)
                     next_rsp.data = {31'h0, (is_wr ? wval[0] : wpp)};
                  else if (pnum == `PNUM_CTRL_WORD)
                     next_rsp.data = {16'h0000, (is_wr ? wval[15:0] & `CW_DEFINED_MASK : ctrl)};
                  else
                  begin
                     next_par_rd = 1'b1;
                     next_rsp.data = PAR_RDATA_IN;
                  end
               end
            end
            next_rsp_valid = 1'b1;
            next_state = ST_ANSWER;
         end
         ST_ANSWER:
            next_state = ST_IDLE;
         default:
            next_state = ST_IDLE;
      endcase
      next_ready = (next_state == ST_IDLE);
   end

   // Registers of the request engine
   always_ff @(posedge CLK_IN)
   begin
      if (RST_IN)
      begin
         state <= ST_IDLE;
         req <= '0;
         pnum <= 16'h0000;
         pre_code <= 8'h00;
         wpp <= `WORDS_PER_PARAM_RESET; // [R1]
         ctrl <= `CTRL_WORD_RESET;
         first_done <= 1'b0;
         ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp <= '0;
         par_wr <= 1'b0;
         par_rd <= 1'b0;
         wdata <= 32'h0;
         map_clear <= 1'b0;
      end
      else
      begin
         state <= next_state;
         req <= next_req;
         pnum <= next_pnum;
         pre_code <= next_pre_code;
         wpp <= next_wpp;
         ctrl <= next_ctrl;
         first_done <= next_first_done;
         ready <= next_ready;
         rsp_valid <= next_rsp_valid;
         rsp <= next_rsp;
         par_wr <= next_par_wr;
         par_rd <= next_par_rd;
         wdata <= next_wdata;
         map_clear <= next_map_clear;
      end
   end

   // Drive command state, from the stored control word
   drv_cmd_t cmd, next_cmd;
   logic trip_prev, next_trip_prev; // Trip reset bit as last seen
   logic trip_pulse, next_trip_pulse;
   logic [3:0] ref_sel, next_ref_sel;
   logic ctrl_wide, next_ctrl_wide; // Control word carried as 32-bit

   // Next drive commands
   always_comb
   begin
      // Commands only follow the word while the fieldbus owns run/stop
      next_cmd.enable = fb_src && sto_ok && ctrl[`CW_ENABLE]; // [R14] [R15]
      next_cmd.run_fwd = fb_src && sto_ok && ctrl[`CW_RUN_FWD]; // [R12] [R15]
      next_cmd.jog = fb_src && sto_ok && ctrl[`CW_JOG];
      next_cmd.run_rev = fb_src && sto_ok && ctrl[`CW_RUN_REV];
      next_cmd.dir_rev = fb_src && ctrl[`CW_DIR_REV];
      next_cmd.run = fb_src && sto_ok && ctrl[`CW_RUN];
      next_cmd.ref_digital = fb_src && ctrl[`CW_REF_SEL]; // [R16]
      // Preset selector 0 leaves digital reference one in use
      next_ref_sel = (pin_s[8:5] == 4'h0) ? 4'h1 : pin_s[8:5]; // [R17]
      next_trip_prev = ctrl[`CW_TRIP_RESET];
      // Uncompressed cyclic data widens the word; registered so the pin sees a flop
      next_ctrl_wide = !pin_s[4]; // [R18]
      // A held bit does not keep resetting; only the 0 to 1 edge counts
      next_trip_pulse = fb_src && ctrl[`CW_TRIP_RESET] && !trip_prev; // [R19]
   end

   // Drive command registers
   always_ff @(posedge CLK_IN)
   begin
      if (RST_IN)
      begin
         cmd <= '0;
         trip_prev <= 1'b0;
         trip_pulse <= 1'b0;
         ref_sel <= 4'h1;
         ctrl_wide <= 1'b0;
      end
      else
      begin
         cmd <= next_cmd;
         ctrl_wide <= next_ctrl_wide;
         trip_prev <= next_trip_prev;
         trip_pulse <= next_trip_pulse;
         ref_sel <= next_ref_sel;
      end
   end

   assign REQ_READY_OUT = ready;
   assign RSP_VALID_OUT = rsp_valid;
   assign RSP_OUT = rsp;
   assign PAR_NUM_OUT = pnum;
   assign PAR_WR_OUT = par_wr;
   assign PAR_RD_OUT = par_rd;
   assign PAR_WDATA_OUT = wdata;
   assign MAP_CLEAR_OUT = map_clear;
   assign DRV_CMD_OUT = cmd;
   assign TRIP_RESET_OUT = trip_pulse;
   assign CTRL_WORD_OUT = {16'h0000, ctrl}; // [R18]
   assign CTRL_WIDE_OUT = ctrl_wide; // [R18]
   assign DIG_REF_SEL_OUT = ref_sel;

   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);

   a_answer_timing: assert property ((state == ST_IDLE && REQ_VALID_IN) |-> ##3 RSP_VALID_OUT)
      else $error("answer not three cycles after request"); // [R3]
   a_below_base: assert property ((state == ST_DECODE && req.addr < `ACYC_BASE_ADDR && fc_ok)
      |-> ##2 (RSP_OUT.exc && RSP_OUT.code == `EXC_ILLEGAL_ADDR))
      else $error("address below base accepted"); // [R4]
   a_two_word_map: assert property ((state == ST_DECODE && wpp)
      |=> pnum == {1'b0, $past(off[15:1])} + 16'h0001)
      else $error("two-word address decode wrong"); // [R5]
   a_one_word_map: assert property ((state == ST_DECODE && !wpp) |=> pnum == $past(off) + 16'h0001)
      else $error("one-word address decode wrong"); // [R6]
   a_menu_zero: assert property ((state == ST_CHECK && pre_code == 8'h00 && pnum < `PNUM_MENU_ONE)
      |=> (RSP_OUT.exc && !PAR_WR_OUT && !PAR_RD_OUT))
      else $error("menu zero parameter accessed"); // [R8]
   a_one_word_wide: assert property ((state == ST_CHECK && PARAM_WIDE_IN && !wpp) |=> RSP_OUT.exc)
      else $error("32-bit access in one-word layout"); // [R2]
   a_single_wide: assert property ((state == ST_CHECK && PARAM_WIDE_IN
      && req.fc == `FC_WRITE_SINGLE) |=> (RSP_OUT.exc && !PAR_WR_OUT))
      else $error("single write to 32-bit parameter"); // [R9]
   a_short_wide: assert property ((state == ST_CHECK && PARAM_WIDE_IN && req.qty < 16'h0002)
      |=> RSP_OUT.exc)
      else $error("short 32-bit access accepted"); // [R10]
   a_map_clear_once: assert property (MAP_CLEAR_OUT |=> !MAP_CLEAR_OUT [*8])
      else $error("output mapping cleared twice"); // [R11]
   a_enable_gate: assert property (DRV_CMD_OUT.enable |-> $past(fb_src && sto_ok))
      else $error("enable without fieldbus source or safe torque inputs"); // [R14] [R15]
   a_trip_edge: assert property (TRIP_RESET_OUT |-> ($past(ctrl[`CW_TRIP_RESET])
      && !$past(trip_prev)) ##1 !TRIP_RESET_OUT)
      else $error("trip reset not a single edge pulse"); // [R19]
endmodule

// >>> sim/mb_master_model.sv
// Modbus master stand-in that hands decoded requests to the block.
// Assumes the bench calls xfer and that the answer follows on clk_in.
`timescale 1ns/1ps
module mb_master_model
   import mb_acyc_pkg::*;
(
   input wire logic clk_in,
   input wire logic ready_in,
   input wire logic rsp_valid_in,
   input wire rsp_t rsp_in,
   output logic valid_out,
   output req_t req_out
);
   // Idle lines at time zero
   initial
   begin
      valid_out = 1'b0;
      req_out = '0;
   end
   // One request, held until taken; ok stays low if anything stalls
   task automatic xfer(input req_t r, output rsp_t a, output bit ok);
      int n;
      ok = 1'b0;
      @(posedge clk_in);
      #1;
      valid_out = 1'b1;
      req_out = r;
      for (n = 0; n < 8 && !ok; n++)
      begin
         ok = ready_in;
         @(posedge clk_in);
      end
      #1;
      valid_out = 1'b0;
      // Released lines flip so a stale request cannot pass for a new one
      req_out = ~r;
      for (n = 0; n < 8 && !rsp_valid_in; n++)
      begin
         @(posedge clk_in);
         #1;
      end
      ok = ok && rsp_valid_in;
      a = rsp_in;
   endtask
endmodule

// >>> sim/modbus_acyclic_param_ctrl_word_tb.sv
// Self-checking bench for non-cyclic access and control word decode.
// Assumes the package, header and master model are compiled first.
`timescale 1ns/1ps
`include "mb_acyc_regs.svh"
`define CHK(g, e) chk(40'(g), 40'(e))
module modbus_acyclic_param_ctrl_word_tb
   import mb_acyc_pkg::*;
();
   logic clk, rst, req_valid, req_ready, rsp_valid, par_wide, par_wr, par_rd;
   logic map_clear, fb_src, sto_a, sto_b, cyc_act, compress, trip, ctrl_wide;
   logic [3:0] preset, dig_ref;
   logic [15:0] par_num;
   logic [31:0] rdata, wdata, ctrl_word;
   req_t req;
   rsp_t rsp, got;
   drv_cmd_t cmd;
   int err_count, n_compared, n_clear, n_trip, n_wr;
   // Drive table: only parameter 302 is 32-bit
   assign par_wide = (par_num == 16'd302);
   assign rdata = par_wide ? {~par_num, par_num} : {16'h0000, par_num};
   modbus_acyclic_param_ctrl_word modbus_acyclic_param_ctrl_word_inst (
      .CLK_IN(clk), .RST_IN(rst), .REQ_VALID_IN(req_valid), .REQ_IN(req),
      .REQ_READY_OUT(req_ready), .RSP_VALID_OUT(rsp_valid), .RSP_OUT(rsp),
      .PAR_NUM_OUT(par_num), .PARAM_WIDE_IN(par_wide), .PAR_RDATA_IN(rdata),
      .PAR_WR_OUT(par_wr), .PAR_RD_OUT(par_rd), .PAR_WDATA_OUT(wdata),
      .MAP_CLEAR_OUT(map_clear), .FIELDBUS_SRC_IN(fb_src), .STO_A_IN(sto_a),
      .STO_B_IN(sto_b), .CYCLIC_ACTIVE_IN(cyc_act), .COMPRESS_IN(compress),
      .PRESET_SEL_IN(preset), .DRV_CMD_OUT(cmd), .TRIP_RESET_OUT(trip),
      .CTRL_WORD_OUT(ctrl_word), .CTRL_WIDE_OUT(ctrl_wide),
      .DIG_REF_SEL_OUT(dig_ref));
   mb_master_model mb_master_model_inst (
      .clk_in(clk), .ready_in(req_ready), .rsp_valid_in(rsp_valid),
      .rsp_in(rsp), .valid_out(req_valid), .req_out(req));
   // Clock at 100 MHz
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Pulse counters for strobes that stand one cycle only
   always @(posedge clk)
   begin
      if (map_clear === 1'b1) n_clear++;
      if (trip === 1'b1) n_trip++;
      if (par_wr === 1'b1) n_wr++;
   end
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [39:0] g, e);
      n_compared++;
      if (g !== e)
      begin
         $display("ERROR %0t got %h expected %h", $time, g, e);
         err_count++;
      end
   endtask
   // One transfer, then one edge so that pulse counters catch the map clear and write strobes
   task automatic xf(input logic [7:0] fc, input logic [15:0] ad, q, w0, w1);
      bit ok;
      mb_master_model_inst.xfer('{fc, ad, q, w0, w1}, got, ok);
      if (!ok)
      begin
         $display("ERROR %0t no answer", $time);
         err_count++;
         results();
      end
      @(posedge clk);
      #1;
   endtask
   // Pins pass a synchroniser, so allow a few edges
   task automatic pins(input logic f, sa, sb, c, input logic [3:0] p);
      fb_src = f;
      sto_a = sa;
      sto_b = sb;
      compress = c;
      preset = p;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic cw(input logic [15:0] v);
      xf(`FC_WRITE_SINGLE, 16'd1810, 16'd1, v, 16'h0000);
      @(posedge clk);
      #1;
   endtask
   task automatic t_reset();
      `CHK(dig_ref, 4'h1);
      `CHK(ctrl_word, 0);
      xf(`FC_READ_HOLDING, 16'd3544, 16'd2, 16'h0, 16'h0);
      `CHK({got.exc, got.data}, 33'h1);
      `CHK(n_clear, 1);
   endtask
   task automatic t_addr();
      xf(`FC_READ_HOLDING, 16'd768, 16'd2, 16'h0, 16'h0);
      `CHK({got.exc, got.data}, 33'd121);
      xf(`FC_READ_HOLDING, 16'd769, 16'd2, 16'h0, 16'h0);
      `CHK({got.exc, got.code}, 9'h102);
      xf(`FC_READ_HOLDING, 16'd526, 16'd2, 16'h0, 16'h0);
      `CHK({got.exc, got.code}, 9'h102);
      xf(`FC_READ_HOLDING, 16'd724, 16'd2, 16'h0, 16'h0);
      `CHK({got.exc, got.code}, 9'h102);
      xf(`FC_READ_HOLDING, 16'd726, 16'd2, 16'h0, 16'h0);
      `CHK({got.exc, got.data}, 33'd100);
   endtask
   task automatic t_codes();
      logic [7:0] fcs [4] = '{8'h03, 8'h06, 8'h10, 8'h17};
      int w;
      foreach (fcs[i])
      begin
         w = n_wr;
         xf(fcs[i], 16'd768, (fcs[i] == 8'h06) ? 16'd1 : 16'd2, 16'h0, 16'h0055);
         `CHK({got.exc, n_wr - w}, {1'b0, 32'(fcs[i] != 8'h03)});
      end
      `CHK(wdata, 32'h0000_0055);
      xf(8'h04, 16'd768, 16'd2, 16'h0, 16'h0);
      `CHK({got.exc, got.code}, 9'h101);
   endtask
   task automatic t_wide();
      xf(`FC_WRITE_SINGLE, 16'd1130, 16'd1, 16'h1, 16'h0);
      `CHK({got.exc, got.code}, 9'h101);
      xf(`FC_READ_HOLDING, 16'd1130, 16'd1, 16'h0, 16'h0);
      `CHK({got.exc, got.code}, 9'h103);
      xf(`FC_WRITE_MULTI, 16'd1130, 16'd1, 16'h1, 16'h0);
      `CHK({got.exc, got.code}, 9'h103);
      xf(`FC_READ_HOLDING, 16'd1130, 16'd2, 16'h0, 16'h0);
      `CHK({got.exc, got.data}, {1'b0, ~16'd302, 16'd302});
   endtask
   task automatic t_oneword();
      xf(`FC_WRITE_SINGLE, 16'd3544, 16'd1, 16'h0, 16'h0);
      `CHK(got.exc, 0);
      xf(`FC_READ_HOLDING, 16'd648, 16'd1, 16'h0, 16'h0);
      `CHK({got.exc, got.data}, 33'd121);
      xf(`FC_READ_HOLDING, 16'd829, 16'd1, 16'h0, 16'h0);
      `CHK({got.exc, got.code}, 9'h102);
      xf(`FC_WRITE_SINGLE, 16'd2036, 16'd1, 16'h2, 16'h0);
      `CHK({got.exc, got.code}, 9'h103);
      xf(`FC_WRITE_SINGLE, 16'd2036, 16'd1, 16'h1, 16'h0);
      `CHK(got.exc, 0);
   endtask
   task automatic t_ctrl();
      int t;
      cw(16'h013f);
      `CHK(cmd, 7'h7f);
      `CHK({ctrl_wide, ctrl_word}, 33'h1_0000_013f);
      cw(16'h0012);
      `CHK(cmd, 7'h24);
      pins(1'b1, 1'b0, 1'b1, 1'b0, 4'h0);
      cw(16'h013f);
      `CHK(cmd, 7'h05);
      pins(1'b1, 1'b1, 1'b0, 1'b0, 4'h0);
      cw(16'h013f);
      `CHK(cmd, 7'h05);
      pins(1'b1, 1'b1, 1'b1, 1'b0, 4'h0);
      cw(16'h0100);
      `CHK(cmd, 7'h01);
      cw(16'h0000);
      `CHK(cmd, 7'h00);
      t = n_trip;
      cw(16'h2000);
      cw(16'h2000);
      `CHK(n_trip - t, 1);
      cw(16'h0000);
      cw(16'h2000);
      `CHK(n_trip - t, 2);
      pins(1'b0, 1'b1, 1'b1, 1'b1, 4'h3);
      cw(16'h0000);
      cw(16'h213f);
      `CHK({n_trip - t, cmd}, {32'd2, 7'h00});
      `CHK({ctrl_wide, ctrl_word[31:16]}, 17'h0);
      `CHK(dig_ref, 4'h3);
   endtask
   // Main sequence
   initial
   begin
      rst = 1'b1;
      cyc_act = 1'b0;
      fb_src = 1'b1;
      sto_a = 1'b1;
      sto_b = 1'b1;
      compress = 1'b0;
      preset = 4'h0;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      t_reset();
      t_addr();
      t_codes();
      t_wide();
      t_oneword();
      t_ctrl();
      `CHK(n_clear, 1);
      results();
   end
endmodule
